/* File: hw/csf_pkg.sv */
// package: flag register layout, reset values, operation codes
package csf_pkg;
   localparam logic [7:0] CSF_ADDR_ALU_RESET_FLAGS = 8'h03;
   localparam int BIT_PIN_WAKE   = 7;
   localparam int BIT_UNUSED     = 6;
   localparam int BIT_PAGE_SEL   = 5;
   localparam int BIT_WDOG_EXP   = 4;
   localparam int BIT_POWER_DOWN = 3;
   localparam int BIT_ZERO       = 2;
   localparam int BIT_NIB_CARRY  = 1;
   localparam int BIT_CARRY      = 0;
   // power-on value: pin-wake 0, page 0, expired 1, power-down 1, alu flags 0
   localparam logic [7:0] CSF_POR_VALUE = 8'h18;
   localparam logic [7:0] CSF_SW_MASK   = 8'hA7;

   typedef enum logic [2:0] {
      CSF_OP_NONE   = 3'h0,
      CSF_OP_ADD    = 3'h1,
      CSF_OP_SUB    = 3'h3,
      CSF_OP_LOGIC  = 3'h2,
      CSF_OP_ROR    = 3'h6,
      CSF_OP_ROL    = 3'h7,
      CSF_OP_CLEAR  = 3'h5
   } csf_op_t;

   typedef struct packed {
      logic    wr_en;
      logic    [7:0] addr;
      logic    [7:0] data;
      csf_op_t op;
      logic    [7:0] opa;
      logic    [7:0] opb;
   } csf_req_t;

   typedef struct packed {
      logic por;
      logic wdt_clear;
      logic sleep;
      logic wdt_timeout;
      logic pin_wake_reset;
      logic other_reset;
   } csf_evt_t;

   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] result;
   } csf_state_t;
endpackage : csf_pkg

/* File: hw/csf_flags.sv */
// module: core flag register with alu flag generation and reset cause flags
//
// Overview of operation
// - flag register may be any instruction's destination, written like a file register
// - flag-updating instruction writing the register keeps alu result flags; bits 7 and 5 still take the result
// - software writes never change watchdog-expired (bit 4) or power-down (bit 3)
// - clear-file on the register zeroes bits 7..5 and sets zero flag
// - bit 5 selects program page: 1 page 1, 0 page 0
// - expired flag set on power-up, watchdog clear, sleep; cleared on time-out
// - power-down flag set on power-up or watchdog clear; cleared on sleep
// - zero flag is 1 when arithmetic or logic result is zero
// - add: nibble carry is carry out of bit 3
// - subtract: nibble carry is inverted borrow from bit 3
// - rotate right loads carry with lsb, rotate left with msb
`timescale 1ns/1ps
module csf_flags
   import csf_pkg::*;
(
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       SRST,
   // instruction and event side
   input  wire csf_req_t   REQ,
   input  wire csf_evt_t   EVT,
   // flag register contents and alu result
   output logic     [7:0]  FLAGS,
   output logic     [7:0]  RESULT,
   output logic            PAGE_SELECT
);

   csf_state_t st;
   csf_state_t next_st;
   logic [8:0] sum;
   logic [4:0] nib;
   logic       dest_hit;
   logic [7:0] res;
   logic       z;
   logic       dc;
   logic       c;
   logic       alu_op;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st  = st;
      sum      = 9'h000;
      nib      = 5'h00;
      res      = 8'h00;
      z        = st.flags[BIT_ZERO];
      dc       = st.flags[BIT_NIB_CARRY];
      c        = st.flags[BIT_CARRY];
      alu_op   = 1'b1;
      dest_hit = REQ.wr_en && (REQ.addr == CSF_ADDR_ALU_RESET_FLAGS);
      case (REQ.op)
         CSF_OP_ADD: begin
            sum = {1'b0, REQ.opa} + {1'b0, REQ.opb};
            nib = {1'b0, REQ.opa[3:0]} + {1'b0, REQ.opb[3:0]};
            res = sum[7:0];
            dc  = nib[4];
            c   = sum[8];
         end
         CSF_OP_SUB: begin
            // opa minus opb; carries stay high when no borrow
            sum = {1'b0, REQ.opa} - {1'b0, REQ.opb};
            nib = {1'b0, REQ.opa[3:0]} - {1'b0, REQ.opb[3:0]};
            res = sum[7:0];
            dc  = ~nib[4];
            c   = ~sum[8];
         end
         CSF_OP_LOGIC: begin
            res = REQ.opa;
         end
         CSF_OP_ROR: begin
            res = {st.flags[BIT_CARRY], REQ.opa[7:1]};
            c   = REQ.opa[0];
         end
         CSF_OP_ROL: begin
            res = {REQ.opa[6:0], st.flags[BIT_CARRY]};
            c   = REQ.opa[7];
         end
         CSF_OP_CLEAR: begin
            res = 8'h00;
         end
         default: begin
            res    = REQ.data;
            alu_op = 1'b0;
         end
      endcase
      // rotates leave zero flag alone, only arithmetic, logic and clear affect it
      if (alu_op && REQ.op != CSF_OP_ROR && REQ.op != CSF_OP_ROL) begin
         z = (res == 8'h00);
      end
      next_st.result = res;
      if (dest_hit) begin
         // plain moves and bit ops write only bits 7, 5 and 2..0; bits 4 and 3 keep their value
         next_st.flags = (st.flags & ~CSF_SW_MASK) | (res & CSF_SW_MASK);
      end
      if (alu_op) begin
         // result flags win over the destination write
         next_st.flags[BIT_ZERO]      = z;
         next_st.flags[BIT_NIB_CARRY] = (REQ.op == CSF_OP_ADD || REQ.op == CSF_OP_SUB) ? dc
                                       : st.flags[BIT_NIB_CARRY];
         next_st.flags[BIT_CARRY]     = c;
      end
      // hardware events last so they win over any software write
      if (EVT.sleep) begin
         next_st.flags[BIT_WDOG_EXP]   = 1'b1;
         next_st.flags[BIT_POWER_DOWN] = 1'b0;
      end
      if (EVT.wdt_clear) begin
         next_st.flags[BIT_WDOG_EXP]   = 1'b1;
         next_st.flags[BIT_POWER_DOWN] = 1'b1;
      end
      if (EVT.wdt_timeout) begin
         next_st.flags[BIT_WDOG_EXP] = 1'b0;
      end
      if (EVT.other_reset) begin
         next_st.flags[BIT_PIN_WAKE] = 1'b0;
         next_st.flags[BIT_PAGE_SEL] = 1'b0;
      end
      if (EVT.pin_wake_reset) begin
         next_st.flags[BIT_PIN_WAKE] = 1'b1;
         next_st.flags[BIT_PAGE_SEL] = 1'b0;
      end
      if (EVT.por) begin
         next_st.flags = CSF_POR_VALUE;
      end
      next_st.flags[BIT_UNUSED] = 1'b0;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         st <= '{flags: CSF_POR_VALUE, result: 8'h00};
      end else begin
         st <= next_st;
      end
   end

   assign FLAGS       = st.flags;
   assign RESULT      = st.result;
   assign PAGE_SELECT = st.flags[BIT_PAGE_SEL];

   ////////////////////////////////////////////////////////////////////////////
   logic quiet;
   assign quiet = !EVT.por && !EVT.sleep && !EVT.wdt_clear && !EVT.wdt_timeout
                  && !EVT.pin_wake_reset && !EVT.other_reset;

   sequence s_add_nib;
      quiet && REQ.op == CSF_OP_ADD && ({1'b0, REQ.opa[3:0]} + {1'b0, REQ.opb[3:0]}) > 5'h0F;
   endsequence

   property p_sw_protect;
      @(posedge CLK) disable iff (SRST)
      quiet && dest_hit ##0 REQ.op == CSF_OP_NONE |=> $stable(FLAGS[4:3]);
   endproperty
   a_sw_protect: assert property (p_sw_protect) else $error("software changed protected flag");

   property p_clear;
      @(posedge CLK) disable iff (SRST)
      quiet && dest_hit && REQ.op == CSF_OP_CLEAR |=> FLAGS[7:5] == 3'h0 && FLAGS[2] && $stable(FLAGS[4:3]);
   endproperty
   a_clear: assert property (p_clear) else $error("clear-file pattern wrong");

   property p_alu_wins;
      @(posedge CLK) disable iff (SRST)
      quiet && dest_hit && REQ.op == CSF_OP_LOGIC |=> FLAGS[2] == (RESULT == 8'h00);
   endproperty
   a_alu_wins: assert property (p_alu_wins) else $error("zero flag overwritten by write");

   property p_sleep;
      @(posedge CLK) disable iff (SRST)
      EVT.sleep && !EVT.wdt_clear && !EVT.wdt_timeout && !EVT.por |=> FLAGS[4] && !FLAGS[3];
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

   property p_timeout;
      @(posedge CLK) disable iff (SRST)
      EVT.wdt_timeout && !EVT.por |=> !FLAGS[4];
   endproperty
   a_timeout: assert property (p_timeout) else $error("time-out did not clear flag");

   property p_add_dc;
      @(posedge CLK) disable iff (SRST)
      s_add_nib |=> FLAGS[1];
   endproperty
   a_add_dc: assert property (p_add_dc) else $error("nibble carry missing");

   property p_sub_c;
      @(posedge CLK) disable iff (SRST)
      quiet && REQ.op == CSF_OP_SUB |=> FLAGS[0] == ($past(REQ.opa) >= $past(REQ.opb));
   endproperty
   a_sub_c: assert property (p_sub_c) else $error("subtract carry wrong");

   property p_ror;
      @(posedge CLK) disable iff (SRST)
      quiet && REQ.op == CSF_OP_ROR |=> FLAGS[0] == $past(REQ.opa[0]);
   endproperty
   a_ror: assert property (p_ror) else $error("rotate carry wrong");

   property p_bit6;
      @(posedge CLK) disable iff (SRST)
      1'b1 |=> !FLAGS[6] ##1 !FLAGS[6];
   endproperty
   a_bit6: assert property (p_bit6) else $error("bit 6 not zero");

   property p_rol;
      @(posedge CLK) disable iff (SRST)
      quiet && REQ.op == CSF_OP_ROL |=> FLAGS[0] == $past(REQ.opa[7]);
   endproperty
   a_rol: assert property (p_rol) else $error("rotate left carry wrong");

   property p_sub_dc;
      @(posedge CLK) disable iff (SRST)
      quiet && REQ.op == CSF_OP_SUB |=> FLAGS[1] == ($past(REQ.opa[3:0]) >= $past(REQ.opb[3:0]));
   endproperty
   a_sub_dc: assert property (p_sub_dc) else $error("subtract nibble carry wrong");

   // plain moves reach every writable bit; the protected pair is covered above
   property p_write_lands;
      @(posedge CLK) disable iff (SRST)
      quiet && dest_hit && REQ.op == CSF_OP_NONE
      |=> {FLAGS[7], FLAGS[5], FLAGS[2:0]} == $past({REQ.data[7], REQ.data[5], REQ.data[2:0]});
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("plain write did not land");

   property p_pin_wake;
      @(posedge CLK) disable iff (SRST)
      EVT.pin_wake_reset && !EVT.por |=> FLAGS[7] && !FLAGS[5];
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin-wake flag not set");

endmodule : csf_flags

/* File: verif/csf_core_model.sv */
// file: behavioural core model that issues instructions and reset events
`timescale 1ns/1ps
module csf_core_model
   import csf_pkg::*;
(
   // clock
   input  wire logic CLK,
   // instruction and event side of the flag register
   output csf_req_t  REQ,
   output csf_evt_t  EVT
);
   initial begin
      REQ = '0;
      EVT = '0;
   end
   // one instruction held for one whole cycle, then an idle cycle; f is the destination address
   task automatic issue(input logic w, input csf_op_t o, input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] d, input logic [7:0] f);
      @(negedge CLK);
      REQ = '{wr_en: w, addr: f, data: d, op: o, opa: a, opb: b};
      @(negedge CLK);
      REQ = '0;
   endtask : issue
   // events are single-cycle pulses
   task automatic event_pulse(input csf_evt_t e);
      @(negedge CLK);
      EVT = e;
      @(negedge CLK);
      EVT = '0;
   endtask : event_pulse
endmodule : csf_core_model

/* File: verif/tb.sv */
// file: self-checking bench for the core flag register
`timescale 1ns/1ps
module tb;
   import csf_pkg::*;
   logic       CLK  = 1'b0;
   logic       SRST = 1'b1;
   csf_req_t   req;
   csf_evt_t   evt;
   logic [7:0] flags;
   logic [7:0] result;
   logic       page;
   int         n_mismatch = 0;
   int         cmp_count  = 0;
   always #5 CLK = ~CLK;
   csf_core_model i_core (.CLK(CLK), .REQ(req), .EVT(evt));
   csf_flags i_dut (.CLK(CLK), .SRST(SRST), .REQ(req), .EVT(evt), .FLAGS(flags), .RESULT(result),
                    .PAGE_SELECT(page));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // written data is the inverse of the expected flags, so a leaked write shows
   task automatic alu(input csf_op_t o, input logic [7:0] a, input logic [7:0] b, input logic [2:0] f);
      i_core.issue(1'b1, o, a, b, {5'h00, ~f}, CSF_ADDR_ALU_RESET_FLAGS);
      chk({5'h00, flags[2:0]}, {5'h00, f});
   endtask : alu
   task automatic wr(input logic [7:0] d, input logic [7:0] e);
      i_core.issue(1'b1, CSF_OP_NONE, 8'h00, 8'h00, d, CSF_ADDR_ALU_RESET_FLAGS);
      chk(flags, e);
   endtask : wr
   task automatic ev(input csf_evt_t p, input logic [7:0] m, input logic [7:0] e);
      i_core.event_pulse(p);
      chk(flags & m, e);
   endtask : ev
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge CLK);
      @(negedge CLK);
      SRST = 1'b0;
      chk(flags, 8'h18);
      $display("test reset done");
      alu(CSF_OP_ADD, 8'h0F, 8'h01, 3'h2);
      chk(result, 8'h10);
      alu(CSF_OP_ADD, 8'hFF, 8'h01, 3'h7);
      alu(CSF_OP_SUB, 8'h05, 8'h06, 3'h0);
      alu(CSF_OP_ROR, 8'h01, 8'h00, 3'h1);
      alu(CSF_OP_ROL, 8'h01, 8'h00, 3'h0);
      alu(CSF_OP_ROL, 8'h80, 8'h00, 3'h1);
      alu(CSF_OP_LOGIC, 8'h00, 8'h00, 3'h5);
      alu(CSF_OP_SUB, 8'h10, 8'h01, 3'h1);
      alu(CSF_OP_SUB, 8'h22, 8'h22, 3'h7);
      $display("test alu flags done");
      wr(8'hFF, 8'hBF);
      chk({7'h00, page}, 8'h01);
      wr(8'h00, 8'h18);
      chk({7'h00, page}, 8'h00);
      wr(8'hA0, 8'hB8);
      i_core.issue(1'b1, CSF_OP_CLEAR, 8'h00, 8'h00, 8'h00, CSF_ADDR_ALU_RESET_FLAGS);
      chk(flags, 8'h1C);
      $display("test writes done");
      ev('{sleep: 1'b1, default: 1'b0}, 8'hFF, 8'h14);
      ev('{wdt_timeout: 1'b1, default: 1'b0}, 8'hFF, 8'h04);
      ev('{wdt_clear: 1'b1, default: 1'b0}, 8'hFF, 8'h1C);
      wr(8'h20, 8'h38);
      ev('{pin_wake_reset: 1'b1, default: 1'b0}, 8'hC0, 8'h80);
      ev('{other_reset: 1'b1, default: 1'b0}, 8'hC0, 8'h00);
      wr(8'hA0, 8'hB8);
      i_core.issue(1'b1, CSF_OP_NONE, 8'h00, 8'h00, 8'h00, 8'h10);
      chk(flags, 8'hB8);
      i_core.issue(1'b0, CSF_OP_NONE, 8'h00, 8'h00, 8'h00, CSF_ADDR_ALU_RESET_FLAGS);
      chk(flags, 8'hB8);
      i_core.issue(1'b1, CSF_OP_ADD, 8'h08, 8'h08, 8'h00, 8'h10);
      chk(flags, 8'hBA);
      chk(result, 8'h10);
      // mid-run reset brings back the power-on pattern
      SRST = 1'b1;
      @(negedge CLK);
      SRST = 1'b0;
      chk(flags, 8'h18);
      $display("test other destinations and reset done");
      wr(8'hA0, 8'hB8);
      ev('{por: 1'b1, default: 1'b0}, 8'hFF, 8'h18);
      $display("test events done");
      tally_and_finish();
   end
   // about 63 cycles of work; the limit leaves ample margin
   initial begin
      #5000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb
